// [design/rsbm_pkg.sv]
// rsbm_pkg: register map, field positions and encodings for the reset-source and boot-mode block
// assumes a 32-bit avalon-mm slave with word addressing on byte offsets
package rsbm_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_RST_CAUSE_0 = 8'h00;
  localparam logic [7:0] OFF_IWDG_STATUS = 8'h04;
  localparam logic [7:0] OFF_SYS_CTRL_1 = 8'h08;
  localparam logic [7:0] OFF_SW_RESET = 8'h0c;
  localparam logic [7:0] OFF_BOOT_MODE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFF_SRC_CAUSE = 8'h20;
  // field positions
  localparam int MON0_FLAG_BIT = 1;
  localparam int MON1_FLAG_BIT = 2;
  localparam int MON2_FLAG_BIT = 3;
  localparam int REFRESH_ERR_BIT = 15;
  localparam int SBY_RAM_EN_BIT = 7;
  // reset values
  localparam logic [7:0] RST_CAUSE_0_RESET = 8'h00;
  localparam logic [15:0] IWDG_STATUS_RESET = 16'h0000;
  localparam logic [15:0] SYS_CTRL_1_RESET = 16'h0000;
  // software reset key, value arbitrary
  localparam logic [15:0] SW_RESET_KEY = 16'ha501;
  // reset source indices, one bit each in cause and irq registers
  localparam int NUM_SRC = 9;
  localparam int SRC_PIN = 0;
  localparam int SRC_POR = 1;
  localparam int SRC_MON0 = 2;
  localparam int SRC_MON1 = 3;
  localparam int SRC_MON2 = 4;
  localparam int SRC_DSBY = 5;
  localparam int SRC_IWDG = 6;
  localparam int SRC_SWDG = 7;
  localparam int SRC_SOFT = 8;
  // boot mode encodings
  typedef enum logic [2:0] {
    RSBM_BOOT_SERIAL = 3'h0,
    RSBM_BOOT_USB = 3'h1,
    RSBM_BOOT_DEBUG = 3'h2,
    RSBM_SINGLE_CHIP = 3'h3
  } rsbm_boot_t;
endpackage

// [design/rsbm_sync.sv]
// rsbm_sync: two-flop synchroniser for a vector of asynchronous levels
// assumes inputs come from pins or analog comparators outside i_clk
`timescale 1ns/1ps
module rsbm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // async levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= INIT;
      o_sync <= INIT;
    end else begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end
endmodule // rsbm_sync

// [design/rsbm_top.sv]
// rsbm_top: reset-source collection, reset cause flags, boot-mode decode, standby ram enable
// assumes avalon-mm master on i_clk; monitor and watchdog events arrive as async levels
//
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Operation
// - reset pin low forces combined reset
// - rising supply past threshold gives power-on reset
// - supply below monitor0 threshold resets
// - monitor1 and monitor2 low supply reset
// - deep standby exit by interrupt resets
// - independent watchdog underflow or refresh error resets
// - system watchdog underflow or refresh error resets
// - cause flags at bits one to three
// - refresh error flag at bit fifteen
// - mode and boot pins select boot mode
// - mode pin rising, boot low: debug boot
// - standby ram enable at bit seven
module rsbm_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // pins
  input wire logic i_external_reset_n,
  input wire logic i_mode_select_pin,
  input wire logic i_boot_select_pin,
  // monitor and watchdog requests
  input wire logic i_power_good,
  input wire logic i_monitor0_low,
  input wire logic i_monitor1_low,
  input wire logic i_monitor2_low,
  input wire logic i_deep_standby_wake,
  input wire logic i_iwdg_underflow,
  input wire logic i_iwdg_refresh_error,
  input wire logic i_swdg_underflow,
  input wire logic i_swdg_refresh_error,
  // results
  output logic o_system_reset,
  output logic [2:0] o_boot_mode,
  output logic o_standby_ram_enable,
  output logic o_irq
);
  localparam int NS = rsbm_pkg::NUM_SRC;

  // synchronised asynchronous inputs
  logic [10:0] sync_in;
  logic pin_reset_n;
  logic mode_pin;
  logic boot_pin;
  logic power_good;
  logic mon0_low;
  logic mon1_low;
  logic mon2_low;
  logic dsby_wake;
  logic iwdg_req;
  logic iwdg_ref_err;
  logic swdg_req;

  rsbm_sync #(
    .WIDTH(11),
    // idle pin and supply levels, so no false edge right after reset
    .INIT(11'h00f)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_swdg_underflow | i_swdg_refresh_error, i_iwdg_refresh_error,
      i_iwdg_underflow | i_iwdg_refresh_error, i_deep_standby_wake, i_monitor2_low,
      i_monitor1_low, i_monitor0_low, i_power_good, i_boot_select_pin, i_mode_select_pin,
      i_external_reset_n}),
    .o_sync(sync_in)
  );

  always_comb begin
    pin_reset_n = sync_in[0];
    mode_pin = sync_in[1];
    boot_pin = sync_in[2];
    power_good = sync_in[3];
    mon0_low = sync_in[4];
    mon1_low = sync_in[5];
    mon2_low = sync_in[6];
    dsby_wake = sync_in[7];
    iwdg_req = sync_in[8];
    iwdg_ref_err = sync_in[9];
    swdg_req = sync_in[10];
  end

  // state
  logic power_good_d;
  logic por_pending;
  logic soft_req;
  logic [NS-1:0] src_req;
  logic [NS-1:0] src_cause;
  logic [7:0] rst_cause_0;
  logic [15:0] iwdg_status;
  logic [15:0] sys_ctrl_1;
  logic [NS-1:0] irq_status;
  logic [NS-1:0] irq_enable;
  logic system_reset;
  logic mode_seen_low;
  rsbm_pkg::rsbm_boot_t boot_mode;
  logic [31:0] readdata;
  logic ack;

  logic next_power_good_d;
  logic next_por_pending;
  logic next_soft_req;
  logic [NS-1:0] next_src_cause;
  logic [7:0] next_rst_cause_0;
  logic [15:0] next_iwdg_status;
  logic [15:0] next_sys_ctrl_1;
  logic [NS-1:0] next_irq_status;
  logic [NS-1:0] next_irq_enable;
  logic next_system_reset;
  logic next_mode_seen_low;
  rsbm_pkg::rsbm_boot_t next_boot_mode;
  logic [31:0] next_readdata;
  logic next_ack;

  // bus decode
  logic access;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wdata_masked;

  always_comb begin
    access = (i_avs_read | i_avs_write) & ~ack;
    wr = i_avs_write & ~ack;
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{i_avs_byteenable[b]}};
    end
    wdata_masked = i_avs_writedata & wmask;
  end

  // per-source request vector
  always_comb begin
    src_req = '0;
    src_req[rsbm_pkg::SRC_PIN] = ~pin_reset_n;
    src_req[rsbm_pkg::SRC_POR] = por_pending;
    src_req[rsbm_pkg::SRC_MON0] = mon0_low;
    src_req[rsbm_pkg::SRC_MON1] = mon1_low;
    src_req[rsbm_pkg::SRC_MON2] = mon2_low;
    src_req[rsbm_pkg::SRC_DSBY] = dsby_wake;
    src_req[rsbm_pkg::SRC_IWDG] = iwdg_req;
    src_req[rsbm_pkg::SRC_SWDG] = swdg_req;
    src_req[rsbm_pkg::SRC_SOFT] = soft_req;
  end

  // reset sources, cause flags and boot mode
  always_comb begin
    next_power_good_d = power_good;
    // only a rising supply counts; a falling one is left to the monitors
    next_por_pending = ~power_good_d & power_good;
    next_soft_req = wr && i_avs_address == rsbm_pkg::OFF_SW_RESET &&
      (i_avs_writedata[15:0] & wmask[15:0]) == rsbm_pkg::SW_RESET_KEY;
    next_system_reset = |src_req;
    next_src_cause = src_cause | src_req;
    next_rst_cause_0 = rst_cause_0;
    next_iwdg_status = iwdg_status;
    next_sys_ctrl_1 = sys_ctrl_1;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_mode_seen_low = mode_seen_low;
    next_boot_mode = boot_mode;
    if (wr && i_avs_address == rsbm_pkg::OFF_RST_CAUSE_0) begin
      // write zero clears a flag; a new event below still wins
      next_rst_cause_0 = rst_cause_0 & (i_avs_writedata[7:0] | ~wmask[7:0]);
    end
    if (wr && i_avs_address == rsbm_pkg::OFF_IWDG_STATUS) begin
      next_iwdg_status = iwdg_status & (i_avs_writedata[15:0] | ~wmask[15:0]);
    end
    if (wr && i_avs_address == rsbm_pkg::OFF_SRC_CAUSE) begin
      next_src_cause = src_req | (src_cause & ~wdata_masked[NS-1:0]);
    end
    if (wr && i_avs_address == rsbm_pkg::OFF_SYS_CTRL_1) begin
      next_sys_ctrl_1 = (sys_ctrl_1 & ~wmask[15:0]) | wdata_masked[15:0];
    end
    if (wr && i_avs_address == rsbm_pkg::OFF_IRQ_ENABLE) begin
      next_irq_enable = (irq_enable & ~wmask[NS-1:0]) | wdata_masked[NS-1:0];
    end
    if (wr && i_avs_address == rsbm_pkg::OFF_IRQ_CLEAR) begin
      next_irq_status = irq_status & ~wdata_masked[NS-1:0];
    end
    // set wins over clear
    next_irq_status = next_irq_status | (src_req & ~src_cause);
    if (mon0_low) begin
      next_rst_cause_0[rsbm_pkg::MON0_FLAG_BIT] = 1'b1;
    end
    if (mon1_low) begin
      next_rst_cause_0[rsbm_pkg::MON1_FLAG_BIT] = 1'b1;
    end
    if (mon2_low) begin
      next_rst_cause_0[rsbm_pkg::MON2_FLAG_BIT] = 1'b1;
    end
    if (iwdg_ref_err) begin
      next_iwdg_status[rsbm_pkg::REFRESH_ERR_BIT] = 1'b1;
    end
    // pins decode while reset is held; frozen once it is released
    if (system_reset) begin
      if (!mode_pin) begin
        next_mode_seen_low = 1'b1;
      end
      if (mode_pin && mode_seen_low && !boot_pin) begin
        next_boot_mode = rsbm_pkg::RSBM_BOOT_DEBUG;
      end else if (mode_pin) begin
        next_boot_mode = rsbm_pkg::RSBM_SINGLE_CHIP;
      end else if (boot_pin) begin
        next_boot_mode = rsbm_pkg::RSBM_BOOT_USB;
      end else begin
        next_boot_mode = rsbm_pkg::RSBM_BOOT_SERIAL;
      end
    end else begin
      next_mode_seen_low = 1'b0;
    end
  end

  // register read mux, one wait cycle then ack
  always_comb begin
    next_ack = access;
    next_readdata = 32'h0000_0000;
    if (access && i_avs_read) begin
      case (i_avs_address)
        rsbm_pkg::OFF_RST_CAUSE_0: next_readdata[7:0] = rst_cause_0;
        rsbm_pkg::OFF_IWDG_STATUS: next_readdata[15:0] = iwdg_status;
        rsbm_pkg::OFF_SYS_CTRL_1: next_readdata[15:0] = sys_ctrl_1;
        rsbm_pkg::OFF_BOOT_MODE: next_readdata[2:0] = boot_mode;
        rsbm_pkg::OFF_IRQ_STATUS: next_readdata[NS-1:0] = irq_status;
        rsbm_pkg::OFF_IRQ_ENABLE: next_readdata[NS-1:0] = irq_enable;
        rsbm_pkg::OFF_SRC_CAUSE: next_readdata[NS-1:0] = src_cause;
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      power_good_d <= 1'b1;
      por_pending <= 1'b0;
      soft_req <= 1'b0;
      src_cause <= '0;
      rst_cause_0 <= rsbm_pkg::RST_CAUSE_0_RESET;
      iwdg_status <= rsbm_pkg::IWDG_STATUS_RESET;
      sys_ctrl_1 <= rsbm_pkg::SYS_CTRL_1_RESET;
      irq_status <= '0;
      irq_enable <= '0;
      system_reset <= 1'b1;
      mode_seen_low <= 1'b0;
      boot_mode <= rsbm_pkg::RSBM_SINGLE_CHIP;
      readdata <= 32'h0000_0000;
      ack <= 1'b0;
    end else begin
      power_good_d <= next_power_good_d;
      por_pending <= next_por_pending;
      soft_req <= next_soft_req;
      src_cause <= next_src_cause;
      rst_cause_0 <= next_rst_cause_0;
      iwdg_status <= next_iwdg_status;
      sys_ctrl_1 <= next_sys_ctrl_1;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      system_reset <= next_system_reset;
      mode_seen_low <= next_mode_seen_low;
      boot_mode <= next_boot_mode;
      readdata <= next_readdata;
      ack <= next_ack;
    end
  end

  always_comb begin
    o_avs_readdata = readdata;
    o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
    o_system_reset = system_reset;
    o_boot_mode = boot_mode;
    o_standby_ram_enable = sys_ctrl_1[rsbm_pkg::SBY_RAM_EN_BIT];
    o_irq = |(irq_status & irq_enable);
  end
endmodule // rsbm_top

// [verif/rsbm_checker.sv]
// rsbm_checker: port-level checks of rsbm_top
// assumes it is bound to rsbm_top, one clock domain
`timescale 1ns/1ps
module rsbm_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // bus
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // pins and results
  input wire logic i_external_reset_n,
  input wire logic i_mode_select_pin,
  input wire logic i_boot_select_pin,
  input wire logic i_power_good,
  input wire logic o_system_reset,
  input wire logic [2:0] o_boot_mode,
  input wire logic o_standby_ram_enable
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic req;
  logic wr_ack;
  assign req = i_avs_read | i_avs_write;
  assign wr_ack = i_avs_write & ~o_avs_waitrequest;
  a_one_wait: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no ack");
  a_idle_ready: assert property (!req |-> !o_avs_waitrequest) else $error("stray wait");
  a_pin_reset: assert property (!i_external_reset_n [*4] |=> o_system_reset) else $error("pin reset");
  a_power_on: assert property ($rose(i_power_good) |-> ##[1:5] o_system_reset) else $error("power on");
  a_soft_reset: assert property (
    wr_ack && i_avs_address == rsbm_pkg::OFF_SW_RESET && i_avs_byteenable[1:0] == 2'h3
    && i_avs_writedata[15:0] == rsbm_pkg::SW_RESET_KEY |-> ##[1:3] o_system_reset) else $error("soft reset");
  a_boot_serial: assert property (
    (o_system_reset && !i_mode_select_pin && !i_boot_select_pin) [*5]
    |-> o_boot_mode == rsbm_pkg::RSBM_BOOT_SERIAL) else $error("serial boot");
  a_boot_single: assert property (
    (o_system_reset && i_mode_select_pin && i_boot_select_pin) [*5]
    |-> o_boot_mode == rsbm_pkg::RSBM_SINGLE_CHIP) else $error("single chip");
  a_boot_hold: assert property (!o_system_reset [*3] |-> $stable(o_boot_mode)) else $error("boot moved");
  a_ram_enable: assert property (
    wr_ack && i_avs_address == rsbm_pkg::OFF_SYS_CTRL_1 && i_avs_byteenable[0]
    |-> o_standby_ram_enable == i_avs_writedata[7]) else $error("ram enable");
  a_unmapped_zero: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address > rsbm_pkg::OFF_SRC_CAUSE
    |-> o_avs_readdata == 32'h0) else $error("unmapped data");
  c_debug: cover property (!o_system_reset && o_boot_mode == rsbm_pkg::RSBM_BOOT_DEBUG);
  c_release: cover property ($fell(o_system_reset));
  c_ram_on: cover property ($rose(o_standby_ram_enable));
endmodule // rsbm_checker
bind rsbm_top rsbm_checker u_chk (.*);

// [verif/rsbm_far_side.sv]
// rsbm_far_side: pins, supply monitors and watchdogs facing rsbm_top
// assumes the bench calls its tasks; levels move just after i_clk rises
`timescale 1ns/1ps
module rsbm_far_side (
  // clock
  input wire logic i_clk,
  // pins
  output logic o_external_reset_n,
  output logic o_mode_select_pin,
  output logic o_boot_select_pin,
  // supply and watchdogs
  output logic o_power_good,
  output logic o_monitor0_low,
  output logic o_monitor1_low,
  output logic o_monitor2_low,
  output logic o_deep_standby_wake,
  output logic o_iwdg_underflow,
  output logic o_iwdg_refresh_error,
  output logic o_swdg_underflow,
  output logic o_swdg_refresh_error
);
  logic [9:0] active = 10'h0;
  logic mode = 1'b1;
  logic boot = 1'b1;
  assign o_external_reset_n = !active[0];
  assign o_power_good = !active[1];
  assign {o_swdg_refresh_error, o_iwdg_refresh_error, o_swdg_underflow, o_iwdg_underflow,
    o_deep_standby_wake, o_monitor2_low, o_monitor1_low, o_monitor0_low} = active[9:2];
  assign o_mode_select_pin = mode;
  assign o_boot_select_pin = boot;
  // supply dip or event held for a chosen time, slow or prompt
  task automatic raise(input int idx, input int cycles);
    @(posedge i_clk);
    active[idx] <= 1'b1;
    repeat (cycles) @(posedge i_clk);
    active[idx] <= 1'b0;
  endtask
  // pin reset with mode pins, mode may move mid-reset
  task automatic boot_cycle(input logic m0, input logic b, input logic m1);
    @(posedge i_clk);
    mode <= m0;
    boot <= b;
    active[0] <= 1'b1;
    repeat (8) @(posedge i_clk);
    mode <= m1;
    repeat (8) @(posedge i_clk);
    active[0] <= 1'b0;
  endtask
endmodule // rsbm_far_side

// [verif/rsbm_top_tb.sv]
// rsbm_top_tb: bus-driven tests of reset sources, flags, irq and boot decode
// assumes rsbm_far_side drives the pins and the checker is bound to rsbm_top
`timescale 1ns/1ps
module rsbm_top_tb;
  logic i_clk, i_rst, i_avs_read, i_avs_write, o_avs_waitrequest, o_system_reset;
  logic [7:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic [3:0] i_avs_byteenable;
  logic [2:0] o_boot_mode;
  logic o_standby_ram_enable, o_irq, i_external_reset_n, i_mode_select_pin, i_boot_select_pin;
  logic i_power_good, i_monitor0_low, i_monitor1_low, i_monitor2_low, i_deep_standby_wake;
  logic i_iwdg_underflow, i_iwdg_refresh_error, i_swdg_underflow, i_swdg_refresh_error;
  logic [2:0] bcase [5] = '{3'h0, 3'h2, 3'h7, 3'h1, 3'h5};
  logic [2:0] bexp [5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h3};
  int num_errors = 0;
  int n_compared = 0;
  int idx;
  rsbm_top u_dut (.*);
  rsbm_far_side u_far (.i_clk(i_clk), .o_external_reset_n(i_external_reset_n),
    .o_mode_select_pin(i_mode_select_pin), .o_boot_select_pin(i_boot_select_pin),
    .o_power_good(i_power_good), .o_monitor0_low(i_monitor0_low), .o_monitor1_low(i_monitor1_low),
    .o_monitor2_low(i_monitor2_low), .o_deep_standby_wake(i_deep_standby_wake),
    .o_iwdg_underflow(i_iwdg_underflow), .o_iwdg_refresh_error(i_iwdg_refresh_error),
    .o_swdg_underflow(i_swdg_underflow), .o_swdg_refresh_error(i_swdg_refresh_error));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge i_clk);
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= b;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, 4'h0);
    check(what, q, exp);
  endtask
  task automatic wait_rst(input logic lvl);
    int n;
    n = 0;
    while (o_system_reset !== lvl && n < 50) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 50) begin
      num_errors++;
      end_of_test();
    end
  endtask
  initial begin
    i_rst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 8'h0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(rsbm_pkg::OFF_RST_CAUSE_0, 32'h0, "cause0 reset");
    rd(rsbm_pkg::OFF_IWDG_STATUS, 32'h0, "iwdg status reset");
    rd(rsbm_pkg::OFF_SYS_CTRL_1, 32'h0, "sysctl1 reset");
    rd(rsbm_pkg::OFF_BOOT_MODE, 32'h3, "boot reg reset");
    bus(1'b1, 8'h24, 32'hffffffff, 4'hf);
    rd(8'h24, 32'h0, "unmapped");
    $display("test registers done");
    bus(1'b1, rsbm_pkg::OFF_IRQ_ENABLE, 32'h1ff, 4'hf);
    for (int s = 0; s < 11; s++) begin
      idx = (s < 8) ? s : s - 2;
      bus(1'b1, rsbm_pkg::OFF_IRQ_CLEAR, 32'h1ff, 4'hf);
      bus(1'b1, rsbm_pkg::OFF_SRC_CAUSE, 32'h1ff, 4'hf);
      if (s == 10) begin
        bus(1'b1, rsbm_pkg::OFF_SW_RESET, {16'h0, rsbm_pkg::SW_RESET_KEY}, 4'hf);
      end else begin
        u_far.raise(s, 6);
      end
      @(negedge i_clk);
      if (s != 1 && s != 10) check("reset held", o_system_reset, 1'b1);
      wait_rst(1'b1);
      wait_rst(1'b0);
      rd(rsbm_pkg::OFF_IRQ_STATUS, 32'h1 << idx, "source status");
      check("irq raised", o_irq, 1'b1);
      rd(rsbm_pkg::OFF_SRC_CAUSE, 32'h1 << idx, "source cause");
    end
    rd(rsbm_pkg::OFF_RST_CAUSE_0, 32'he, "cause0 flags");
    rd(rsbm_pkg::OFF_IWDG_STATUS, 32'h8000, "refresh flag");
    bus(1'b1, rsbm_pkg::OFF_RST_CAUSE_0, 32'h0, 4'hf);
    bus(1'b1, rsbm_pkg::OFF_IWDG_STATUS, 32'h0, 4'hf);
    rd(rsbm_pkg::OFF_RST_CAUSE_0, 32'h0, "cause0 cleared");
    rd(rsbm_pkg::OFF_IWDG_STATUS, 32'h0, "refresh cleared");
    bus(1'b1, rsbm_pkg::OFF_IRQ_ENABLE, 32'h0, 4'hf);
    @(negedge i_clk);
    check("irq masked", o_irq, 1'b0);
    bus(1'b1, rsbm_pkg::OFF_IRQ_CLEAR, 32'h1ff, 4'hf);
    bus(1'b1, rsbm_pkg::OFF_IRQ_ENABLE, 32'h1ff, 4'hf);
    @(negedge i_clk);
    check("irq cleared", o_irq, 1'b0);
    bus(1'b1, rsbm_pkg::OFF_SW_RESET, 32'h1234, 4'hf);
    repeat (6) begin
      @(negedge i_clk);
      check("wrong key", o_system_reset, 1'b0);
    end
    $display("test sources done");
    bus(1'b1, rsbm_pkg::OFF_SYS_CTRL_1, 32'h80, 4'hf);
    rd(rsbm_pkg::OFF_SYS_CTRL_1, 32'h80, "sysctl1");
    bus(1'b1, rsbm_pkg::OFF_SYS_CTRL_1, 32'h0, 4'he);
    @(negedge i_clk);
    check("ram enable masked", o_standby_ram_enable, 1'b1);
    bus(1'b1, rsbm_pkg::OFF_SYS_CTRL_1, 32'h0, 4'hf);
    @(negedge i_clk);
    check("ram enable off", o_standby_ram_enable, 1'b0);
    for (int k = 0; k < 5; k++) begin
      u_far.boot_cycle(bcase[k][2], bcase[k][1], bcase[k][0]);
      wait_rst(1'b0);
      @(negedge i_clk);
      check("boot mode", o_boot_mode, bexp[k]);
    end
    @(posedge i_clk);
    u_far.mode <= 1'b0;
    u_far.boot <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd(rsbm_pkg::OFF_BOOT_MODE, 32'h3, "boot frozen");
    $display("test boot done");
    end_of_test();
  end
endmodule // rsbm_top_tb
